// [common/contour_consts.vh]
// How it works
// - Contour operation is enabled per axis by an axis-select mask; unselected axes keep their other-mode command.
// - A segment lasts two to the power of the interval exponent in ms, the exponent running from 1 to 8.
// - Within a segment each selected axis moves linearly from start to start plus increment, one new point per ms.
// - The next queued segment is taken only after the current interval has fully elapsed, and a complete flag is offered.
// - An interval exponent of zero followed by a zero increment leaves contour operation.
// - With no segment queued the block holds position and emits no new points until data arrives.
// - A malformed segment record is refused and flagged as an error instead of being run.
// - Each increment is signed and limited to plus or minus 32000 counts.
// - The last interval exponent is kept and applied to every later segment.
// - Segments follow one another without limit on count or path length.
`ifndef CONTOUR_CONSTS_VH
`define CONTOUR_CONSTS_VH
`define NUM_AXES 2
`define POS_W 32
`define INC_W 16
`define INC_LIMIT 16'sd32000
`define EXP_MIN 4'h1
`define EXP_MAX 4'h8
`define TICK_NS 1000000
`define CLK_NS 10
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define REG_CTRL 4'h0
`define REG_EXP 4'h1
`define REG_INC0 4'h2
`define REG_INC1 4'h3
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h5
`define REG_IRQ_MASK 4'h6
`define REG_POS0 4'h7
`define REG_POS1 4'h8
`define REG_FREE0 4'h9
`define REG_FREE1 4'hA
`define IRQ_DONE 0
`define IRQ_ERR 1
`define IRQ_EXIT 2
`define IRQ_STARVE 3
`define IRQ_W 4
`endif

// [rtl/axis_interp.v]
`timescale 1ns/1ps
`default_nettype none
`include "contour_consts.vh"
module axis_interp (
   input wire core_clk_i,
   input wire rst_i,
   input wire load_i,
   input wire step_i,
   input wire [3:0] exp_i,
   input wire signed [`INC_W-1:0] inc_i,
   input wire signed [`POS_W-1:0] start_i,
   output reg signed [`POS_W-1:0] pos_o
);
   // ----------------------------------------
   // Linear stepper, exact product then shift each point
   // ----------------------------------------
   reg signed [`POS_W-1:0] base_r;
   reg signed [`INC_W-1:0] inc_r;
   reg [3:0] exp_r;
   reg [8:0] k_r;
   wire [8:0] k_nxt;
   wire signed [`INC_W+9:0] prod;
   wire signed [`INC_W+9:0] quo;

   assign k_nxt = k_r + 9'h001;
   // Exact product then shift: no lost fraction, last point lands on base + inc
   assign prod = inc_r * $signed({1'b0, k_nxt});
   assign quo = prod >>> exp_r;

   // Base captured at load, points follow k/2^n of the increment
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         base_r <= 32'sh0;
         inc_r <= 16'sh0;
         exp_r <= 4'h1;
         k_r <= 9'h000;
         pos_o <= 32'sh0;
      end else if (load_i) begin
         base_r <= start_i;
         inc_r <= inc_i;
         exp_r <= exp_i;
         k_r <= 9'h000;
         pos_o <= start_i;
      end else if (step_i) begin
         k_r <= k_nxt;
         pos_o <= base_r + {{(`POS_W-`INC_W-10){quo[`INC_W+9]}}, quo};
      end
   end
endmodule
`default_nettype wire

// [rtl/contour_segment_interpolator.v]
`timescale 1ns/1ps
`default_nettype none
`include "contour_consts.vh"
module contour_segment_interpolator (
   input wire core_clk_i,
   input wire rst_i,
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   output reg [`NUM_AXES*`POS_W-1:0] cmd_pos_o,
   output reg [`NUM_AXES-1:0] contour_active_o,
   output reg tick_o,
   output reg irq_o
);
   // ----------------------------------------
   // State and registers
   // ----------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_WAIT = 4'b0010;
   localparam [3:0] ST_RUN = 4'b0100;
   localparam [3:0] ST_EXITP = 4'b1000;

   reg [3:0] state_r;
   reg [`NUM_AXES-1:0] axis_sel_r;
   reg [3:0] exp_r;
   reg exit_armed_r;
   reg [`INC_W-1:0] inc_r [0:`NUM_AXES-1];
   reg pend_r;
   reg [`POS_W-1:0] free_r [0:`NUM_AXES-1];
   reg [`IRQ_W-1:0] irq_stat_r;
   reg [`IRQ_W-1:0] irq_mask_r;
   reg [31:0] seg_count_r;
   reg [16:0] tick_cnt_r;
   reg [8:0] left_r;
   reg err_r;
   reg ack_r;
   reg [`IRQ_W-1:0] ev;
   reg load;
   reg step;

   wire [3:0] reg_idx;
   wire wr_acc;
   wire rd_acc;
   wire tick;
   wire [`NUM_AXES*`POS_W-1:0] interp_pos;
   wire [8:0] seg_len;
   wire exp_ok;
   wire inc_ok;
   wire [`NUM_AXES-1:0] inc_ok_v;
   wire all_zero;
   wire [`NUM_AXES-1:0] zero_v;

   // Word-aligned byte addressing, index sits above the two lane bits
   assign reg_idx = avs_address_i[5:2];
   assign wr_acc = avs_write_i && avs_waitrequest_o;
   assign rd_acc = avs_read_i && avs_waitrequest_o;
   assign tick = ({15'h0000, tick_cnt_r} == `TICK_CYCLES - 1);
   assign seg_len = 9'h001 << exp_r;
   assign exp_ok = (exp_r >= `EXP_MIN) && (exp_r <= `EXP_MAX);
   assign inc_ok = &inc_ok_v;
   assign all_zero = &zero_v;

   // ----------------------------------------
   // Per-axis datapath
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `NUM_AXES; g = g + 1) begin : ax
         wire signed [`INC_W-1:0] inc_s;
         assign inc_s = inc_r[g];
         // Range check on every increment, selected axis or not
         assign inc_ok_v[g] = (inc_s <= `INC_LIMIT) && (inc_s >= -`INC_LIMIT);
         assign zero_v[g] = (inc_r[g] == 16'h0000);
         axis_interp u_interp (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .load_i(load && axis_sel_r[g]),
            .step_i(step && axis_sel_r[g]),
            .exp_i(exp_r),
            .inc_i(inc_s),
            .start_i(cmd_pos_o[g*`POS_W +: `POS_W]),
            .pos_o(interp_pos[g*`POS_W +: `POS_W])
         );
         // Unselected axes pass the free-mode command straight through
         always @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               cmd_pos_o[g*`POS_W +: `POS_W] <= 32'h00000000;
               contour_active_o[g] <= 1'b0;
            end else begin
               contour_active_o[g] <= axis_sel_r[g] && (state_r != ST_IDLE);
               if (axis_sel_r[g] && (state_r != ST_IDLE))
                  cmd_pos_o[g*`POS_W +: `POS_W] <= interp_pos[g*`POS_W +: `POS_W];
               else
                  cmd_pos_o[g*`POS_W +: `POS_W] <= free_r[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Next-state decisions and one-cycle event flags
   always @* begin
      ev = {`IRQ_W{1'b0}};
      load = 1'b0;
      step = 1'b0;
      case (state_r)
         ST_IDLE: begin
         end
         ST_WAIT: begin
            // Segment taken only once the previous interval ran out
            if (pend_r && !exit_armed_r && exp_ok && inc_ok)
               load = 1'b1;
         end
         ST_RUN: begin
            step = tick;
            if (tick && left_r == 9'h001)
               ev[`IRQ_DONE] = 1'b1;
         end
         ST_EXITP: begin
         end
         default: begin
         end
      endcase
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         left_r <= 9'h000;
         seg_count_r <= 32'h00000000;
         tick_cnt_r <= 17'h00000;
         tick_o <= 1'b0;
      end else begin
         tick_cnt_r <= tick ? 17'h00000 : tick_cnt_r + 17'h00001;
         tick_o <= tick && (state_r == ST_RUN);
         case (state_r)
            ST_IDLE: begin
               if (wr_acc && reg_idx == `REG_CTRL && avs_writedata_i[`NUM_AXES-1:0] != {`NUM_AXES{1'b0}})
                  state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               // Stays here with contour positions frozen while starved
               if (load) begin
                  state_r <= ST_RUN;
                  left_r <= seg_len;
                  seg_count_r <= seg_count_r + 32'h00000001;
               end else if (pend_r && exit_armed_r && all_zero)
                  state_r <= ST_EXITP;
            end
            ST_RUN: begin
               if (tick) begin
                  left_r <= left_r - 9'h001;
                  if (left_r == 9'h001)
                     state_r <= ST_WAIT;
               end
            end
            ST_EXITP: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Segment intake and error check
   // ----------------------------------------
   // Exit needs exponent 0 first, then a zero increment record
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         exp_r <= `EXP_MIN;
         exit_armed_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         err_r <= 1'b0;
         if (load || state_r == ST_EXITP)
            pend_r <= 1'b0;
         else if (state_r == ST_WAIT && pend_r && !all_zero && (exit_armed_r || !inc_ok)) begin
            pend_r <= 1'b0;
            err_r <= 1'b1;
         end
         if (wr_acc && reg_idx == `REG_EXP) begin
            if (avs_writedata_i[3:0] == 4'h0) begin
               // Zero only arms the exit while contouring, idle keeps the old exponent
               if (state_r != ST_IDLE)
                  exit_armed_r <= 1'b1;
            end else if (avs_writedata_i[31:4] == 28'h0 && avs_writedata_i[3:0] <= `EXP_MAX) begin
               exp_r <= avs_writedata_i[3:0];
               exit_armed_r <= 1'b0;
            end else
               err_r <= 1'b1;
         end
         if (state_r == ST_EXITP)
            exit_armed_r <= 1'b0;
         // Last increment word written commits the record
         if (wr_acc && reg_idx == `REG_INC1 && state_r != ST_IDLE) begin
            if (pend_r)
               err_r <= 1'b1;
            else
               pend_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Register writes and interrupt
   // ----------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         axis_sel_r <= {`NUM_AXES{1'b0}};
         irq_stat_r <= {`IRQ_W{1'b0}};
         irq_mask_r <= {`IRQ_W{1'b0}};
         inc_r[0] <= 16'h0000;
         inc_r[1] <= 16'h0000;
         free_r[0] <= 32'h00000000;
         free_r[1] <= 32'h00000000;
         irq_o <= 1'b0;
      end else begin
         // Axis set is fixed while contouring to keep axes consistent
         if (wr_acc && reg_idx == `REG_CTRL && state_r == ST_IDLE)
            axis_sel_r <= avs_writedata_i[`NUM_AXES-1:0];
         if (wr_acc && reg_idx == `REG_INC0 && !pend_r)
            inc_r[0] <= avs_writedata_i[`INC_W-1:0];
         if (wr_acc && reg_idx == `REG_INC1 && !pend_r)
            inc_r[1] <= avs_writedata_i[`INC_W-1:0];
         if (wr_acc && reg_idx == `REG_FREE0)
            free_r[0] <= avs_writedata_i;
         if (wr_acc && reg_idx == `REG_FREE1)
            free_r[1] <= avs_writedata_i;
         if (wr_acc && reg_idx == `REG_IRQ_MASK)
            irq_mask_r <= avs_writedata_i[`IRQ_W-1:0];
         // Set wins over write-one-to-clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~((wr_acc && reg_idx == `REG_IRQ_STAT) ?
                       avs_writedata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
                       | ev | {state_r == ST_WAIT && !pend_r, state_r == ST_EXITP, err_r, 1'b0};
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ----------------------------------------
   // Avalon slave, one wait cycle per access
   // ----------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
         ack_r <= 1'b0;
      end else begin
         ack_r <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         if ((avs_read_i || avs_write_i) && avs_waitrequest_o && !ack_r) begin
            avs_waitrequest_o <= 1'b0;
            ack_r <= 1'b1;
         end
         if (rd_acc && !ack_r) begin
            case (reg_idx)
               `REG_CTRL: avs_readdata_o <= {30'h0, axis_sel_r};
               `REG_EXP: avs_readdata_o <= {27'h0, exit_armed_r, exp_r};
               `REG_INC0: avs_readdata_o <= {{16{inc_r[0][15]}}, inc_r[0]};
               `REG_INC1: avs_readdata_o <= {{16{inc_r[1][15]}}, inc_r[1]};
               `REG_STATUS: avs_readdata_o <= {seg_count_r[23:0], pend_r, 3'h0, state_r};
               `REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat_r};
               `REG_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask_r};
               `REG_POS0: avs_readdata_o <= cmd_pos_o[31:0];
               `REG_POS1: avs_readdata_o <= cmd_pos_o[63:32];
               `REG_FREE0: avs_readdata_o <= free_r[0];
               `REG_FREE1: avs_readdata_o <= free_r[1];
               default: avs_readdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [verif/contour_segment_interpolator_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "contour_consts.vh"
module contour_segment_interpolator_asserts (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [`NUM_AXES*`POS_W-1:0] cmd_pos_o,
   input wire logic [`NUM_AXES-1:0] contour_active_o,
   input wire logic tick_o,
   input wire logic irq_o
);
   localparam int TICK_GAP = `TICK_CYCLES - 1;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = avs_read_i || avs_write_i;
   logic [19:0] gap_r;
   logic seen_r;
   // ----------------------------------------
   // Tick spacing helper
   // ----------------------------------------
   // Saturates so a long starved wait cannot wrap into a false short gap
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_r <= 20'h0;
         seen_r <= 1'b0;
      end else if (tick_o) begin
         gap_r <= 20'h0;
         seen_r <= 1'b1;
      end else if (gap_r != 20'hFFFFF) begin
         gap_r <= gap_r + 20'h1;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_tick_spacing: assert property (tick_o && seen_r |-> gap_r >= TICK_GAP)
      else $error("tick points closer than one millisecond");
   a_reset_quiet: assert property ($fell(rst_i) |-> avs_waitrequest_o && !tick_o && !irq_o
      && contour_active_o == 2'h0 && cmd_pos_o == 64'h0) else $error("outputs not at reset values");
   a_answer_next: assert property ($rose(req) |=> !avs_waitrequest_o)
      else $error("no bus answer one cycle after request");
   a_grant_needs_req: assert property (!avs_waitrequest_o |-> req && $past(req))
      else $error("waitrequest low without a held request");
   a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[5:2] > 4'hA
      |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   a_tick_when_active: assert property (tick_o |-> contour_active_o != 2'h0)
      else $error("point generated outside contour operation");
   a_pos_on_tick: assert property (contour_active_o[0] && $past(contour_active_o[0])
      && $past(contour_active_o[0], 2) && $changed(cmd_pos_o[`POS_W-1:0]) |-> tick_o || $past(tick_o))
      else $error("contour position moved without a point");
   a_mode_cause: assert property ($changed(contour_active_o) |-> $past(avs_write_i) || $past(avs_write_i, 2)
      || $past(avs_write_i, 3) || $past(tick_o) || $past(tick_o, 2))
      else $error("axis selection changed without cause");
   cover property (tick_o);
   cover property ($rose(irq_o));
   cover property ($fell(contour_active_o[0]));
endmodule
bind contour_segment_interpolator contour_segment_interpolator_asserts chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .cmd_pos_o(cmd_pos_o),
   .contour_active_o(contour_active_o), .tick_o(tick_o), .irq_o(irq_o));
`default_nettype wire

// [verif/segment_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "contour_consts.vh"
module segment_host (
   input wire logic core_clk_i,
   input wire logic avs_waitrequest_i,
   input wire logic [31:0] avs_readdata_i,
   output logic [5:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [31:0] avs_writedata_o,
   output logic [3:0] avs_byteenable_o
);
   // ----------------------------------------
   // Idle bus
   // ----------------------------------------
   initial begin
      avs_address_o = 6'h0;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0;
      avs_byteenable_o = 4'hF;
   end
   // Held until waitrequest is sampled low; stale fields inverted on release
   task automatic bus_wr(input logic [3:0] idx, input logic [31:0] data);
      @(posedge core_clk_i);
      avs_address_o <= {idx, 2'b00};
      avs_writedata_o <= data;
      avs_write_o <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
      avs_write_o <= 1'b0;
      avs_address_o <= ~{idx, 2'b00};
      avs_writedata_o <= ~data;
   endtask
   task automatic bus_rd(input logic [3:0] idx, output logic [31:0] data);
      @(posedge core_clk_i);
      avs_address_o <= {idx, 2'b00};
      avs_read_o <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
      data = avs_readdata_i;
      avs_read_o <= 1'b0;
      avs_address_o <= ~{idx, 2'b00};
   endtask
   // Record sent whole, second word commits it
   task automatic send_record(input logic [15:0] inc0, input logic [15:0] inc1);
      bus_wr(`REG_INC0, {{16{inc0[15]}}, inc0});
      bus_wr(`REG_INC1, {{16{inc1[15]}}, inc1});
   endtask
endmodule
`default_nettype wire

// [verif/test_contour_segment_interpolator.sv]
`timescale 1ns/1ps
`default_nettype none
`include "contour_consts.vh"
module test_contour_segment_interpolator;
   logic core_clk_i;
   logic rst_i;
   wire logic [5:0] adr;
   wire logic rd, wr, wreq;
   wire logic [31:0] wdat, rdat;
   wire logic [3:0] be;
   wire logic [63:0] cmd_pos_o;
   wire logic [1:0] contour_active_o;
   wire logic tick_o, irq_o;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   time t0;
   logic [31:0] d;
   logic [63:0] p;
   contour_segment_interpolator dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cmd_pos_o(cmd_pos_o),
      .contour_active_o(contour_active_o), .tick_o(tick_o), .irq_o(irq_o));
   segment_host host (.core_clk_i(core_clk_i), .avs_waitrequest_i(wreq), .avs_readdata_i(rdat),
      .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wdat), .avs_byteenable_o(be));
   // ----------------------------------------
   // Clock, verdict and hang guard
   // ----------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (exp !== got) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Ceiling covers the first millisecond point plus bus traffic
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 101000) begin
         fail_count++;
         finish_test;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_i = 1'b1;
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t0 = $time;
      host.bus_rd(`REG_STATUS, d);
      check("idle status", 32'h1, d);
      host.bus_rd(4'hF, d);
      check("unmapped read", 32'h0, d);
      host.bus_wr(`REG_CTRL, 32'h1);
      // Active flag follows the state register one edge later
      @(posedge core_clk_i);
      check("active axes", 32'h1, {30'h0, contour_active_o});
      p = cmd_pos_o;
      // Starved: nothing may move while no record is queued
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk_i);
         check("tick while waiting", 32'h0, {31'h0, tick_o});
      end
      check("held position", p[31:0], cmd_pos_o[31:0]);
      host.bus_rd(`REG_IRQ_STAT, d);
      check("starved flag", 32'h1, {31'h0, d[`IRQ_STARVE]});
      host.bus_wr(`REG_IRQ_MASK, 32'h2);
      host.bus_wr(`REG_EXP, 32'h1);
      host.send_record(16'h7D01, 16'h0);
      host.bus_rd(`REG_IRQ_STAT, d);
      check("error flag", 32'h1, {31'h0, d[`IRQ_ERR]});
      check("error irq", 32'h1, {31'h0, irq_o});
      host.bus_rd(`REG_STATUS, d);
      check("status after reject", 32'h2, d);
      host.bus_wr(`REG_IRQ_STAT, 32'h2);
      repeat (3) @(posedge core_clk_i);
      check("irq cleared", 32'h0, {31'h0, irq_o});
      host.bus_wr(`REG_EXP, 32'h9);
      host.bus_rd(`REG_IRQ_STAT, d);
      check("bad exponent flag", 32'h1, {31'h0, d[`IRQ_ERR]});
      host.bus_rd(`REG_EXP, d);
      check("kept exponent", 32'h1, d);
      host.bus_wr(`REG_IRQ_STAT, 32'h2);
      host.bus_wr(`REG_EXP, 32'h0);
      host.send_record(16'h0, 16'h0);
      repeat (3) @(posedge core_clk_i);
      check("exit axes", 32'h0, {30'h0, contour_active_o});
      host.bus_rd(`REG_STATUS, d);
      check("exit state", 32'h1, {28'h0, d[3:0]});
      host.bus_wr(`REG_CTRL, 32'h1);
      host.bus_wr(`REG_EXP, 32'h1);
      host.send_record(16'd48, 16'h0);
      host.bus_rd(`REG_STATUS, d);
      check("run state", 32'h4, {28'h0, d[3:0]});
      host.send_record(16'd10, 16'h0);
      host.bus_rd(`REG_STATUS, d);
      check("queued while running", 32'h84, {24'h0, d[7:0]});
      host.bus_wr(`REG_INC1, 32'h0);
      host.bus_rd(`REG_IRQ_STAT, d);
      check("commit while pending", 32'h1, {31'h0, d[`IRQ_ERR]});
      // Millisecond tick runs free from reset, so the first point lands one period after it
      do @(posedge core_clk_i); while (tick_o !== 1'b1);
      n = int'(($time - t0) / `CLK_NS);
      check("first point delay", 32'h1, {31'h0, n >= `TICK_CYCLES && n <= `TICK_CYCLES + 2});
      repeat (2) @(posedge core_clk_i);
      check("half step", 32'd24, cmd_pos_o[31:0]);
      check("free axis", 32'h0, cmd_pos_o[63:32]);
      finish_test;
   end
endmodule
`default_nettype wire
